/* pkg/adc_list_regs.vh */
/*
 * register indices, field positions, reset values and timing counts
 * of the command and result list addressing slice.
 * assumes the byte address of a register is four times its index.
 */
`ifndef ADC_LIST_REGS_VH
`define ADC_LIST_REGS_VH

// ****************************************
// register indices
// ****************************************
`define IDX_CTRL 6'h00
`define IDX_STATUS 6'h01
`define IDX_MASK 6'h02
`define IDX_PRESCALE 6'h03
`define IDX_CMD_BYTE2 6'h16
`define IDX_CMD_BYTE3 6'h17
`define IDX_CMD_POS 6'h1c
`define IDX_CMD_BASE 6'h1d
`define IDX_RES_POS 6'h20
`define IDX_RES_BASE 6'h21
`define IDX_OFF0 6'h24
`define IDX_OFF1 6'h25

// ****************************************
// control fields
// ****************************************
`define CTRL_ENABLE 0
`define CTRL_SMOD 1
`define CTRL_LIST 2
`define CTRL_START 3
`define CTRL_BUSY 4
`define CTRL_HALT 5

// ****************************************
// status and mask fields
// ****************************************
`define ST_CMD_ERR 0
`define ST_RES_DONE 1
`define ST_W 2

// ****************************************
// sample time field and mapping
// ****************************************
`define SMP_HI 7
`define SMP_LO 3
`define SMP_MAX_CODE 5'h14
`define SMP_BASE_CYCLES 6'h04

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_CMD_BASE 22'h000000
`define RST_RES_BASE 18'h00000
`define RST_OFF 7'h00
`define RST_PRESCALE 7'h00

`endif

/* rtl/adc_list_ctrl.v */
/*
 * command and result list addressing of a list based converter:
 * avalon-mm register slave, command fetch, sample timing, result store.
 * assumes memory and the analog core run on clock_i.
 */
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "adc_list_regs.vh"

// Notes on behaviour
// [R1] reserved command pattern sets error flag and halts all conversion
// [R2] sample time byte readable always, writable only under special mode access
// [R3] five-bit code in upper byte bits selects sample length
// [R4] codes 0..20 give 4..24 cycles; higher codes raise command error
// [R5] sample cycles counted in conversion clocks from the prescaler
// [R6] software changes commands under special access only when idle; the code accepts such writes in any state
// [R7] read-only command position counts 32-bit commands within active list
// [R8] command base bits 23:2, writable when disabled or special access
// [R9] fetch address from command base and the active list
// [R10] read-only six-bit result position in 16-bit units
// [R11] result base bits 19:2; result written there at conversion end
// [R12] result base writable when disabled or under special access
// [R13] list 0 offset fixed zero; list 1 offset seven bits
// [R14] fetch = base+4*(offset+position); store = base+2*(offset+position)
module adc_list_ctrl (
    input wire clock_i, // system clock, 250 mhz
    input wire rstn_i, // async reset, active low
    input wire [7:0] avs_address_i, // byte address
    input wire avs_read_i, // register read
    input wire avs_write_i, // register write
    input wire [31:0] avs_writedata_i, // write data
    output reg [31:0] avs_readdata_o, // read data
    output wire avs_waitrequest_o, // slave stall
    output reg [23:0] mem_address_o, // list memory byte address
    output reg mem_read_o, // command fetch
    output reg mem_write_o, // result store
    output reg [15:0] mem_writedata_o, // result value
    input wire [31:0] mem_readdata_i, // fetched command word
    input wire mem_waitrequest_i, // memory stall
    output wire sample_o, // sample phase active
    input wire conv_done_i, // analog conversion finished, pulse
    input wire [11:0] conv_result_i, // conversion result
    output wire irq_o // level interrupt
);

// ****************************************
// states
// ****************************************
localparam ST_IDLE = 3'd0;
localparam ST_FETCH = 3'd1;
localparam ST_CHECK = 3'd2;
localparam ST_SAMPLE = 3'd3;
localparam ST_CONV = 3'd4;
localparam ST_STORE = 3'd5;
localparam ST_HALT = 3'd6;

// ****************************************
// reset synchroniser
// ****************************************
reg rst_meta_r;
reg rst_n;
always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
        rst_meta_r <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta_r <= 1'b1;
        rst_n <= rst_meta_r;
    end
end

// ****************************************
// registers
// ****************************************
reg enable_r;
reg smod_r;
reg list_r;
reg [`ST_W-1:0] status_r;
reg [`ST_W-1:0] mask_r;
reg [6:0] prescale_r;
reg [7:0] byte2_r;
reg [7:0] byte3_r;
reg [7:0] cmd_pos_r;
reg [21:0] cmd_base_r;
reg [5:0] res_pos_r;
reg [17:0] res_base_r;
reg [6:0] off1_r;
reg ack_r;
reg [2:0] state_r;
reg [`ST_W-1:0] ev_set;
reg start_sample;

wire [5:0] idx = avs_address_i[7:2];
wire req = avs_read_i | avs_write_i;
wire wr = avs_write_i & ack_r;
wire cfg_ok = !enable_r || smod_r; // [R8] [R12]
wire [6:0] offset = list_r ? off1_r : `RST_OFF; // [R13]
wire [4:0] smp_code = byte2_r[`SMP_HI:`SMP_LO];
wire smp_bad = (smp_code > `SMP_MAX_CODE); // [R4]
wire [5:0] smp_cycles = {1'b0, smp_code} + `SMP_BASE_CYCLES; // [R3] [R4]
wire timer_busy;
wire timer_done;
wire [`ST_W-1:0] w1c = (wr && idx == `IDX_STATUS) ? avs_writedata_i[`ST_W-1:0] : {`ST_W{1'b0}};
wire trigger = wr && idx == `IDX_CTRL && avs_writedata_i[`CTRL_START];

// ****************************************
// address arithmetic
// ****************************************
// element offset into a list, scaled to bytes
function [23:0] list_addr;
    input [23:0] base;
    input [6:0] off;
    input [7:0] pos;
    input wide;
    reg [8:0] sum;
    begin
        sum = {2'b00, off} + {1'b0, pos};
        list_addr = base + (wide ? {13'h0000, sum, 2'b00} : {14'h0000, sum, 1'b0}); // [R14]
    end
endfunction

wire [23:0] fetch_addr = list_addr({cmd_base_r, 2'b00}, offset, cmd_pos_r, 1'b1); // [R9]
wire [23:0] store_addr = list_addr({4'h0, res_base_r, 2'b00}, offset, {2'b00, res_pos_r},
    1'b0); // [R11]

// ****************************************
// avalon slave
// ****************************************
assign avs_waitrequest_o = req & ~ack_r;

always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        ack_r <= 1'b0;
        avs_readdata_o <= 32'h00000000;
    end else begin
        ack_r <= req & ~ack_r;
        if (avs_read_i && !ack_r) begin
            case (idx)
                `IDX_CTRL: avs_readdata_o <= {26'h0000000, state_r == ST_HALT,
                    state_r != ST_IDLE && state_r != ST_HALT, 1'b0, list_r, smod_r, enable_r};
                `IDX_STATUS: avs_readdata_o <= {30'h00000000, status_r};
                `IDX_MASK: avs_readdata_o <= {30'h00000000, mask_r};
                `IDX_PRESCALE: avs_readdata_o <= {25'h0000000, prescale_r};
                `IDX_CMD_BYTE2: avs_readdata_o <= {24'h000000, byte2_r}; // [R2]
                `IDX_CMD_BYTE3: avs_readdata_o <= {24'h000000, byte3_r};
                `IDX_CMD_POS: avs_readdata_o <= {24'h000000, cmd_pos_r}; // [R7]
                `IDX_CMD_BASE: avs_readdata_o <= {8'h00, cmd_base_r, 2'b00};
                `IDX_RES_POS: avs_readdata_o <= {26'h0000000, res_pos_r}; // [R10]
                `IDX_RES_BASE: avs_readdata_o <= {12'h000, res_base_r, 2'b00};
                `IDX_OFF0: avs_readdata_o <= 32'h00000000; // [R13]
                `IDX_OFF1: avs_readdata_o <= {25'h0000000, off1_r};
                default: avs_readdata_o <= 32'h00000000;
            endcase
        end
    end
end

// ****************************************
// configuration registers
// ****************************************
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        enable_r <= 1'b0;
        smod_r <= 1'b0;
        list_r <= 1'b0;
        mask_r <= {`ST_W{1'b0}};
        prescale_r <= `RST_PRESCALE;
        cmd_base_r <= `RST_CMD_BASE;
        res_base_r <= `RST_RES_BASE;
        off1_r <= `RST_OFF;
        status_r <= {`ST_W{1'b0}};
    end else begin
        status_r <= (status_r & ~w1c) | ev_set; // set wins over clear
        if (wr) begin
            case (idx)
                `IDX_CTRL: begin
                    enable_r <= avs_writedata_i[`CTRL_ENABLE];
                    smod_r <= avs_writedata_i[`CTRL_SMOD];
                    list_r <= avs_writedata_i[`CTRL_LIST];
                end
                `IDX_MASK: mask_r <= avs_writedata_i[`ST_W-1:0];
                `IDX_PRESCALE: prescale_r <= avs_writedata_i[6:0];
                `IDX_CMD_BASE: if (cfg_ok) cmd_base_r <= avs_writedata_i[23:2]; // [R8]
                `IDX_RES_BASE: if (cfg_ok) res_base_r <= avs_writedata_i[19:2]; // [R12]
                `IDX_OFF1: if (cfg_ok) off1_r <= avs_writedata_i[6:0]; // [R13]
                default: begin
                end
            endcase
        end
    end
end

assign irq_o = |(status_r & mask_r);

// ****************************************
// sample timer
// ****************************************
sample_timer #(
    .PRS_W(7),
    .CNT_W(6)
) u_timer (
    .clock_i(clock_i),
    .rstn_i(rst_n),
    .start_i(start_sample),
    .prescale_i(prescale_r),
    .cycles_i(smp_cycles),
    .busy_o(timer_busy),
    .done_o(timer_done)
);

assign sample_o = timer_busy;

// ****************************************
// sequencer
// ****************************************
always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_IDLE;
        byte2_r <= `RST_BYTE;
        byte3_r <= `RST_BYTE;
        cmd_pos_r <= 8'h00;
        res_pos_r <= 6'h00;
        mem_address_o <= 24'h000000;
        mem_read_o <= 1'b0;
        mem_write_o <= 1'b0;
        mem_writedata_o <= 16'h0000;
        ev_set <= {`ST_W{1'b0}};
        start_sample <= 1'b0;
    end else begin
        ev_set <= {`ST_W{1'b0}};
        start_sample <= 1'b0;
        if (wr && smod_r && idx == `IDX_CMD_BYTE2) begin
            byte2_r <= avs_writedata_i[7:0]; // [R2] [R6]
        end
        if (wr && smod_r && idx == `IDX_CMD_BYTE3) begin
            byte3_r <= avs_writedata_i[7:0];
        end
        // disabling abandons the sequence and rewinds both positions
        if (!enable_r) begin
            state_r <= ST_IDLE;
            mem_read_o <= 1'b0;
            mem_write_o <= 1'b0;
            cmd_pos_r <= 8'h00;
            res_pos_r <= 6'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (trigger) begin
                        mem_address_o <= fetch_addr; // [R9]
                        mem_read_o <= 1'b1;
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (!mem_waitrequest_i) begin
                        mem_read_o <= 1'b0;
                        byte2_r <= mem_readdata_i[15:8];
                        byte3_r <= mem_readdata_i[7:0];
                        state_r <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (smp_bad) begin
                        ev_set[`ST_CMD_ERR] <= 1'b1; // [R1]
                        state_r <= ST_HALT;
                    end else begin
                        start_sample <= 1'b1;
                        state_r <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (timer_done) begin
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done_i) begin
                        mem_address_o <= store_addr; // [R11]
                        mem_writedata_o <= {4'h0, conv_result_i};
                        mem_write_o <= 1'b1;
                        state_r <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (!mem_waitrequest_i) begin
                        mem_write_o <= 1'b0;
                        cmd_pos_r <= cmd_pos_r + 8'h01; // [R7]
                        res_pos_r <= res_pos_r + 6'h01; // [R10]
                        ev_set[`ST_RES_DONE] <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_HALT: begin
                    // only clearing enable leaves the halt
                    state_r <= ST_HALT; // [R1]
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
end

endmodule

/* rtl/sample_timer.v */
/*
 * sample phase timer: divides the system clock into the conversion
 * clock and counts the sample length in conversion clock periods.
 * assumes start_i is a one-cycle pulse while the timer is idle.
 */
`timescale 1ns/1ns
module sample_timer #(
    parameter PRS_W = 7,
    parameter CNT_W = 6
) (
    input wire clock_i, // system clock
    input wire rstn_i, // synchronised reset, active low
    input wire start_i, // start pulse
    input wire [PRS_W-1:0] prescale_i, // conversion clock divider
    input wire [CNT_W-1:0] cycles_i, // sample length in conv clocks
    output reg busy_o, // sample phase running
    output reg done_o // pulse at end of sample phase
);

reg [PRS_W-1:0] div_r;
reg [CNT_W-1:0] cnt_r;
wire tick;

// conversion clock period is prescale_i+1 system clocks
assign tick = (div_r == prescale_i);

always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
        div_r <= {PRS_W{1'b0}};
        cnt_r <= {CNT_W{1'b0}};
        busy_o <= 1'b0;
        done_o <= 1'b0;
    end else begin
        done_o <= 1'b0;
        if (start_i && !busy_o) begin
            div_r <= {PRS_W{1'b0}};
            cnt_r <= cycles_i;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            div_r <= tick ? {PRS_W{1'b0}} : div_r + 1'b1; // [R5]
            if (tick) begin
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
end

endmodule

/* verification/adc_list_ctrl_props.sv */
/* checker for the register bus and list memory handshakes.
   assumes it is bound to adc_list_ctrl. */
`timescale 1ns/1ns
module adc_list_ctrl_props (
    input wire clock_i, // clock
    input wire rstn_i, // reset, active low
    input wire avs_read_i, // register read
    input wire avs_write_i, // register write
    input wire avs_waitrequest_o, // slave stall
    input wire [23:0] mem_address_o, // memory address
    input wire mem_read_o, // fetch
    input wire mem_write_o, // store
    input wire [15:0] mem_writedata_o, // result
    input wire mem_waitrequest_i, // memory stall
    input wire sample_o, // sample phase
    input wire irq_o // interrupt
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    wire req = avs_read_i | avs_write_i;
    bus_first_a: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("first access cycle not stalled");
    bus_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access longer than two cycles");
    fetch_hold_a: assert property (mem_read_o && mem_waitrequest_i |=>
        mem_read_o && $stable(mem_address_o)) else $error("fetch dropped early");
    store_hold_a: assert property (mem_write_o && mem_waitrequest_i |=>
        mem_write_o && $stable({mem_address_o, mem_writedata_o}))
        else $error("store dropped early");
    one_access_a: assert property (!(mem_read_o && mem_write_o))
        else $error("fetch and store together");
    fetch_word_a: assert property (mem_read_o |-> mem_address_o[1:0] == 2'h0)
        else $error("fetch address not word aligned");
    store_half_a: assert property (mem_write_o |-> !mem_address_o[0]
        && mem_writedata_o[15:12] == 4'h0) else $error("bad store");
    sample_min_a: assert property ($rose(sample_o) |-> sample_o[*4])
        else $error("sample phase too short");
    sample_quiet_a: assert property (sample_o |-> !mem_read_o && !mem_write_o)
        else $error("memory access during sample");
    cover property ($fell(sample_o));
    cover property (mem_write_o && !mem_waitrequest_i);
    cover property ($rose(irq_o));
endmodule

bind adc_list_ctrl adc_list_ctrl_props u_adc_list_ctrl_props (
    .clock_i(clock_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .mem_address_o(mem_address_o), .mem_read_o(mem_read_o),
    .mem_write_o(mem_write_o), .mem_writedata_o(mem_writedata_o),
    .mem_waitrequest_i(mem_waitrequest_i), .sample_o(sample_o), .irq_o(irq_o)
);

/* verification/adc_list_ctrl_test.sv */
/* bench: registers, fetch, sample length, store, reserved codes.
   assumes list_memory on the memory side. */
`timescale 1ns/1ns
`include "adc_list_regs.vh"
module adc_list_ctrl_test;
reg clock_i = 0, rstn_i = 0, rd = 0, wr = 0, cd = 0, lst;
reg [7:0] adr = 0;
reg [31:0] wd = 0, q, word = 0, seed = 32'h43dee242;
reg [11:0] res = 0;
reg [1:0] dly = 0;
reg [23:0] cb, rb;
reg [6:0] off1, off, prs;
reg [4:0] code;
wire [31:0] rdat, mrd;
wire [23:0] ma;
wire [15:0] mwd;
wire wt, mr, mw, mwt, smp, irq;
integer failures = 0, num_checks = 0, i, n, j, k, cp, rp;
always #2 clock_i = ~clock_i;
adc_list_ctrl u_adc_list_ctrl (.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .mem_address_o(ma), .mem_read_o(mr), .mem_write_o(mw),
    .mem_writedata_o(mwd), .mem_readdata_i(mrd), .mem_waitrequest_i(mwt),
    .sample_o(smp), .conv_done_i(cd), .conv_result_i(res), .irq_o(irq));
list_memory u_list_memory (.clock_i(clock_i), .read_i(mr), .write_i(mw),
    .delay_i(dly), .word_i(word), .readdata_o(mrd), .waitrequest_o(mwt));
task print_verdict;
begin
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
end
endtask
task tmo;
begin
    failures = failures + 1;
    $display("CHECK FAILED %0t timeout", $time);
    print_verdict;
end
endtask
task cmp(input [31:0] got, input [31:0] exp, input [8*10:1] what);
begin
    num_checks = num_checks + 1;
    if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %0t %0s got %h exp %h", $time, what, got, exp);
    end
end
endtask
// expected list addresses and sample lengths
function [23:0] list_expect(input [23:0] base, input [6:0] ofs, input integer pos,
    input integer size);
begin
    list_expect = base + size * (ofs + pos);
end
endfunction
function integer sample_expect(input [4:0] smp, input [6:0] div);
begin
    sample_expect = (smp + 4) * (div + 1);
end
endfunction
task bus(input w, input [5:0] idx, input [31:0] d);
begin
    @(posedge clock_i);
    adr <= {idx, 2'h0};
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    @(posedge clock_i);
    while (wt) begin
        n = n + 1;
        if (n > 20) tmo;
        @(posedge clock_i);
    end
    q = rdat;
    rd <= 0;
    wr <= 0;
end
endtask
task hs(input s);
begin
    n = 0;
    @(negedge clock_i);
    while (!((s ? mw : mr) && !mwt)) begin
        n = n + 1;
        if (n > 99) tmo;
        @(negedge clock_i);
    end
end
endtask
task conv(input err);
begin
    word <= {16'h0, code, 11'h0};
    dly <= $random(seed);
    bus(1, `IDX_CTRL, 9 | lst << 2);
    hs(0);
    cmp(ma, list_expect(cb, off, cp, 4), "fetch");
    i = 0;
    for (n = 0; n < 400 && !(i > 0 && !smp); n = n + 1) begin
        @(negedge clock_i);
        if (smp) i = i + 1;
    end
    if (!err && n >= 400) tmo;
    cmp(i, err ? 0 : sample_expect(code, prs), "sample");
    if (!err) begin
        @(posedge clock_i);
        res <= $random(seed);
        cd <= 1;
        @(posedge clock_i);
        cd <= 0;
        hs(1);
        cmp(ma, list_expect(rb, off, rp, 2), "store");
        cmp(mwd, {4'h0, res}, "result");
        cp = cp + 1;
        rp = rp + 1;
        repeat (3) @(posedge clock_i);
        bus(0, `IDX_CMD_BYTE2, 0);
        cmp(q, {code, 3'h0}, "byte2");
    end else begin
        bus(0, `IDX_CTRL, 0);
        cmp(q[5], 1, "halt");
    end
    bus(0, `IDX_STATUS, 0);
    cmp(q, err ? 1 : 2, "status");
    cmp(irq, 1, "irq");
    bus(1, `IDX_MASK, 0);
    @(negedge clock_i);
    cmp(irq, 0, "masked");
    bus(1, `IDX_MASK, 3);
    bus(1, `IDX_STATUS, 3);
    @(negedge clock_i);
    cmp(irq, 0, "cleared");
    if (err) begin
        bus(1, `IDX_CTRL, 0);
        cp = 0;
        rp = 0;
    end
    bus(0, `IDX_CMD_POS, 0);
    cmp(q, cp & 255, "cmd pos");
    bus(0, `IDX_RES_POS, 0);
    cmp(q, rp & 63, "res pos");
end
endtask
initial begin
    repeat (5) @(posedge clock_i);
    rstn_i <= 1;
    repeat (3) @(posedge clock_i);
    bus(1, `IDX_CMD_BYTE2, 32'hf8);
    bus(0, `IDX_CMD_BYTE2, 0);
    cmp(q, 0, "byte2 lock");
    bus(1, `IDX_CTRL, 2);
    bus(1, `IDX_CMD_BYTE2, 32'ha8);
    bus(0, `IDX_CMD_BYTE2, 0);
    cmp(q, 32'ha8, "byte2");
    bus(1, `IDX_OFF0, 32'h7f);
    bus(0, `IDX_OFF0, 0);
    cmp(q, 0, "off0");
    bus(1, 6'h3f, 32'hff);
    bus(0, 6'h3f, 0);
    cmp(q, 0, "unmapped");
    bus(1, `IDX_CTRL, 1);
    bus(1, `IDX_CMD_BASE, 32'hfffffc);
    bus(1, `IDX_RES_BASE, 32'hffffc);
    bus(0, `IDX_CMD_BASE, 0);
    cmp(q, 0, "cbase lock");
    bus(0, `IDX_RES_BASE, 0);
    cmp(q, 0, "rbase lock");
    bus(1, `IDX_MASK, 3);
    for (k = 0; k < 3; k = k + 1) begin
        bus(1, `IDX_CTRL, 0);
        cp = 0;
        rp = 0;
        cb = $random(seed) & 24'hfffffc;
        rb = $random(seed) & 24'hffffc;
        off1 = $random(seed);
        prs = $random(seed) & 7;
        lst = k[0];
        off = lst ? off1 : 0;
        bus(1, `IDX_CMD_BASE, cb);
        bus(1, `IDX_OFF1, off1);
        bus(1, `IDX_PRESCALE, prs);
        bus(1, `IDX_CTRL, 3 | lst << 2);
        bus(1, `IDX_RES_BASE, rb);
        bus(0, `IDX_RES_BASE, 0);
        cmp(q, rb, "rbase");
        bus(0, `IDX_CMD_BASE, 0);
        cmp(q, cb, "cbase");
        for (j = 0; j < 4; j = j + 1) begin
            code = j ? ($random(seed) & 31) % 21 : 20 * k[0];
            conv(0);
        end
        code = 21 + k * 5;
        conv(1);
    end
    print_verdict;
end
endmodule

/* verification/list_memory.sv */
/* list memory: serves one command word, accepts stores after stalls.
   assumes requests are held until waitrequest is seen low. */
`timescale 1ns/1ns
module list_memory (
    input wire clock_i, // clock
    input wire read_i, // fetch
    input wire write_i, // store
    input wire [1:0] delay_i, // stall cycles
    input wire [31:0] word_i, // command served
    output wire [31:0] readdata_o, // fetched word
    output wire waitrequest_o // stall
);
    reg [1:0] cnt_r = 2'h0;
    assign waitrequest_o = (read_i | write_i) ? cnt_r != delay_i : 1'b1;
    // garbage outside the accepting cycle
    assign readdata_o = (read_i && !waitrequest_o) ? word_i : ~word_i;
    always @(posedge clock_i) begin
        if (!(read_i | write_i) || !waitrequest_o) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule
